/* File: logic/tmic_hyst.sv */
// hysteretic threshold flag on the thermistor result
`timescale 1ns/1ps
module tmic_hyst #(
  parameter logic [6:0] SET_LVL  = 7'h00,
  parameter logic [6:0] CLR_LVL  = 7'h00,
  parameter bit         HIGH_SET = 1'b1
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       update,
  input  wire logic [6:0] value,
  output logic            flag
);
  import tmic_pkg::*;

  logic set_hit;
  logic clr_hit;
  logic flag_reg;

  // compare in the direction given by HIGH_SET
  assign set_hit = HIGH_SET ? (value >= SET_LVL) : (value <= SET_LVL);
  assign clr_hit = HIGH_SET ? (value <= CLR_LVL) : (value >= CLR_LVL);

  // flag only moves on a fresh result
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      flag_reg <= 1'b0;
    else if (update)
    begin
      // (R2) (R4) set level reached
      if (set_hit)
        flag_reg <= 1'b1;
      // (R3) (R5) clear level reached
      else if (clr_hit)
        flag_reg <= 1'b0;
    end
  end

  assign flag = flag_reg;

endmodule : tmic_hyst

/* File: logic/tmic_pkg.sv */
// shared constants and types for the thermistor monitor and input control block
package tmic_pkg;

  // register sub addresses and unmapped read data
  localparam logic [7:0] INPUT_CTRL_ADDR = 8'h00;
  localparam logic [7:0] WALL_PRIO_ADDR  = 8'h01;
  localparam logic [7:0] THERM_RES_ADDR  = 8'h06;
  localparam logic [7:0] TEMP_STAT_ADDR  = 8'h07;
  localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

  // field positions
  localparam int UVCL_DIS_BIT = 7;
  localparam int OTG_LOCK_BIT = 6;
  localparam int PRIO_BIT     = 7;
  localparam int LIMIT_MSB    = 4;
  localparam int MSB_BIT      = 7;

  // reset values of the limit fields
  localparam logic [4:0] USB_LIMIT_RST  = 5'h00;
  localparam logic [4:0] WALL_LIMIT_RST = 5'h1f;

  // thermistor thresholds, 102 / 98 / 19 / 23
  localparam logic [6:0] COLD_SET_LVL = 7'h66;
  localparam logic [6:0] COLD_CLR_LVL = 7'h62;
  localparam logic [6:0] HOT_SET_LVL  = 7'h13;
  localparam logic [6:0] HOT_CLR_LVL  = 7'h17;

  // temperature status and charger state codes
  localparam logic [1:0] TEMP_OK   = 2'h0;
  localparam logic [1:0] TEMP_COLD = 2'h1;
  localparam logic [1:0] TEMP_HOT  = 2'h2;
  localparam logic [2:0] CHG_COLD  = 3'h5;
  localparam logic [2:0] CHG_HOT   = 3'h6;

  // sample period timing
  localparam int CLK_HZ            = 125_000_000;
  localparam int MS_PER_S          = 1000;
  localparam int SAMPLE_PERIOD_MS  = 2400;
  localparam int SAMPLE_CYCLES_DEF = (CLK_HZ / MS_PER_S) * SAMPLE_PERIOD_MS;

  // serial port
  localparam logic [6:0] I2C_DEV_ADDR  = 7'h2a; // arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_A, ST_SUB, ST_ACK_S,
    ST_WDATA, ST_ACK_W, ST_RDATA, ST_RACK
  } tmic_i2c_st_t;

endpackage : tmic_pkg

/* File: logic/tmic_top.sv */
// thermistor monitor and input control registers behind a serial port
//
// Notes on behaviour
// (R1) thermistor result readable, seven bits unsigned
// (R2) cold warning sets at result 102
// (R3) cold warning clears at result 98
// (R4) hot fault sets at result 19
// (R5) hot fault clears at result 23
// (R6) charging paused while either flag active
// (R7) two-bit temperature status field readable
// (R8) charger state shows flags when enabled
// (R9) optional interrupt on window entry or exit
// (R10) optional interrupt on hot fault
// (R11) sample every 2.4 s except ship-store
// (R12) undervoltage limit disable, bit 7, 0x00
// (R13) otg autostart lockout, bit 6, 0x00
// (R14) five-bit usb and wall limit codes
// (R15) limit fields revert when power absent
// (R16) input priority select, bit 7, 0x01
// (R17) control fields written and read back
// (R18) limit fields read active mode
`timescale 1ns/1ps
module tmic_top #(
  parameter int SAMPLE_CYCLES = tmic_pkg::SAMPLE_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       usb_pwr_ok,
  input  wire logic       wall_pwr_ok,
  input  wire logic       ship_store_mode,
  input  wire logic [6:0] adc_result,
  input  wire logic       adc_done,
  output logic            conv_start,
  output logic            thermistor_bias_supply,
  output logic [6:0]      thermistor_result,
  output logic            cold_battery_warning,
  output logic            critical_hot_fault,
  output logic            charge_pause,
  output logic [1:0]      temp_status_field,
  input  wire logic [2:0] charger_state_in,
  input  wire logic       charger_enabled,
  output logic [2:0]      charger_status,
  input  wire logic       chg_irq_en,
  input  wire logic       hot_irq_en,
  output logic            chg_irq_req,
  output logic            hot_irq_req,
  output logic            undervoltage_limit_disable,
  output logic            otg_autostart_lockout,
  output logic [4:0]      usb_input_limit_code,
  output logic [4:0]      wall_input_limit_code,
  output logic            usb_priority
);
  import tmic_pkg::*;

  // pin synchronisers and edge history
  logic [3:0]   sync1_reg;
  logic [3:0]   sync2_reg;
  logic [1:0]   dly_reg;
  logic         scl_s;
  logic         sda_s;
  logic         usb_ok;
  logic         wall_ok;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_cond;
  logic         stop_cond;

  // serial port state
  tmic_i2c_st_t st_reg;
  logic [3:0]   bit_cnt_reg;
  logic [7:0]   shift_reg;
  logic [7:0]   sub_reg;
  logic [7:0]   tx_reg;
  logic         rw_reg;
  logic         sda_oe_reg;
  logic         sda_o_reg;
  logic         wr_pulse_reg;
  logic [7:0]   wr_addr_reg;
  logic [7:0]   wr_data_reg;
  logic [7:0]   rd_byte;
  logic         wr_ctrl;
  logic         wr_prio;

  // control registers
  logic         uvcl_dis_reg;
  logic         otg_lock_reg;
  logic [4:0]   usb_limit_reg;
  logic [4:0]   wall_limit_reg;
  logic         prio_reg;

  // sampling and temperature state
  logic [31:0]  sample_cnt_reg;
  logic         busy_reg;
  logic         conv_start_reg;
  logic         bias_reg;
  logic         sample_done;
  logic [6:0]   therm_reg;
  logic         cold_flag;
  logic         hot_flag;
  logic         in_window;
  logic         pause_reg;
  logic [1:0]   temp_stat_reg;
  logic [2:0]   chg_stat_reg;
  logic         window_prev_reg;
  logic         hot_prev_reg;
  logic         chg_irq_reg;
  logic         hot_irq_reg;

  // two flops on the scl, sda and power-good pins, third stage only for edges
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_reg <= 4'hf;
      sync2_reg <= 4'hf;
      dly_reg   <= 2'h3;
    end
    else
    begin
      sync1_reg <= {wall_pwr_ok, usb_pwr_ok, sda_in, scl_in};
      sync2_reg <= sync1_reg;
      dly_reg   <= sync2_reg[1:0];
    end
  end

  // bus conditions from synchronised levels
  assign scl_s      = sync2_reg[0];
  assign sda_s      = sync2_reg[1];
  assign usb_ok     = sync2_reg[2];
  assign wall_ok    = sync2_reg[3];
  assign scl_rise   = scl_s & ~dly_reg[0];
  assign scl_fall   = ~scl_s & dly_reg[0];
  assign start_cond = scl_s & dly_reg[0] & dly_reg[1] & ~sda_s;
  assign stop_cond  = scl_s & dly_reg[0] & ~dly_reg[1] & sda_s;

  // serial port state machine, bits move on scl edges
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg       <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      sub_reg      <= 8'h00;
      tx_reg       <= 8'h00;
      rw_reg       <= 1'b0;
      sda_oe_reg   <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_addr_reg  <= 8'h00;
      wr_data_reg  <= 8'h00;
    end
    else
    begin
      wr_pulse_reg <= 1'b0;
      if (start_cond)
      begin
        st_reg      <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_reg  <= 1'b0;
      end
      else if (stop_cond)
      begin
        st_reg     <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (st_reg)
          ST_ADDR, ST_SUB, ST_WDATA, ST_RDATA:
          begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          ST_RACK:
          begin
            // master nack ends the read
            if (sda_s)
              st_reg <= ST_IDLE;
          end
          default:
          begin
          end
        endcase
      end
      else if (scl_fall)
      begin
        case (st_reg)
          ST_ADDR:
          begin
            if (bit_cnt_reg == BITS_PER_BYTE)
            begin
              bit_cnt_reg <= 4'h0;
              if (shift_reg[7:1] == I2C_DEV_ADDR)
              begin
                rw_reg     <= shift_reg[0];
                sda_oe_reg <= 1'b1;
                st_reg     <= ST_ACK_A;
              end
              else
                st_reg <= ST_IDLE;
            end
          end
          ST_ACK_A:
          begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg)
            begin
              // (R1) first read bit driven
              tx_reg     <= rd_byte;
              sda_oe_reg <= ~rd_byte[MSB_BIT];
              st_reg     <= ST_RDATA;
            end
            else
            begin
              sda_oe_reg <= 1'b0;
              st_reg     <= ST_SUB;
            end
          end
          ST_SUB:
          begin
            if (bit_cnt_reg == BITS_PER_BYTE)
            begin
              sub_reg     <= shift_reg;
              bit_cnt_reg <= 4'h0;
              sda_oe_reg  <= 1'b1;
              st_reg      <= ST_ACK_S;
            end
          end
          ST_ACK_S, ST_ACK_W:
          begin
            sda_oe_reg <= 1'b0;
            st_reg     <= ST_WDATA;
          end
          ST_WDATA:
          begin
            if (bit_cnt_reg == BITS_PER_BYTE)
            begin
              // (R17) byte handed to the registers
              wr_pulse_reg <= 1'b1;
              wr_addr_reg  <= sub_reg;
              wr_data_reg  <= shift_reg;
              sub_reg      <= sub_reg + 8'h01;
              bit_cnt_reg  <= 4'h0;
              sda_oe_reg   <= 1'b1;
              st_reg       <= ST_ACK_W;
            end
          end
          ST_RDATA:
          begin
            if (bit_cnt_reg == BITS_PER_BYTE)
            begin
              sda_oe_reg  <= 1'b0;
              sub_reg     <= sub_reg + 8'h01;
              bit_cnt_reg <= 4'h0;
              st_reg      <= ST_RACK;
            end
            else
            begin
              sda_oe_reg <= ~tx_reg[MSB_BIT - 1];
              tx_reg     <= {tx_reg[6:0], 1'b0};
            end
          end
          ST_RACK:
          begin
            // master acked, next byte
            tx_reg     <= rd_byte;
            sda_oe_reg <= ~rd_byte[MSB_BIT];
            st_reg     <= ST_RDATA;
          end
          default:
          begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // data line never driven high
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sda_o_reg <= 1'b0;
    else
      sda_o_reg <= 1'b0;
  end

  // read data for the current sub address
  always_comb
  begin
    case (sub_reg)
      // (R17) (R18) stored or active values
      INPUT_CTRL_ADDR: rd_byte = {uvcl_dis_reg, otg_lock_reg, 1'b0, usb_limit_reg};
      WALL_PRIO_ADDR:  rd_byte = {prio_reg, 2'b00, wall_limit_reg};
      // (R1) result in the low seven bits
      THERM_RES_ADDR:  rd_byte = {1'b0, therm_reg};
      // (R7) (R8) status readback
      TEMP_STAT_ADDR:  rd_byte = {chg_stat_reg, 3'b000, temp_stat_reg};
      default:         rd_byte = UNMAPPED_DATA;
    endcase
  end

  assign wr_ctrl = wr_pulse_reg & (wr_addr_reg == INPUT_CTRL_ADDR);
  assign wr_prio = wr_pulse_reg & (wr_addr_reg == WALL_PRIO_ADDR);

  // plain control bits
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      uvcl_dis_reg <= 1'b0;
      otg_lock_reg <= 1'b0;
      prio_reg     <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        // (R12) undervoltage limit disable
        uvcl_dis_reg <= wr_data_reg[UVCL_DIS_BIT];
        // (R13) otg start-up lockout
        otg_lock_reg <= wr_data_reg[OTG_LOCK_BIT];
      end
      // (R16) input priority select
      if (wr_prio)
        prio_reg <= wr_data_reg[PRIO_BIT];
    end
  end

  // input limit codes, forced to default without power
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      usb_limit_reg  <= USB_LIMIT_RST;
      wall_limit_reg <= WALL_LIMIT_RST;
    end
    else
    begin
      // (R15) usb field revert
      if (!usb_ok)
        usb_limit_reg <= USB_LIMIT_RST;
      // (R14) usb code write
      else if (wr_ctrl)
        usb_limit_reg <= wr_data_reg[LIMIT_MSB:0];
      // (R15) wall field revert
      if (!wall_ok)
        wall_limit_reg <= WALL_LIMIT_RST;
      // (R14) wall code write
      else if (wr_prio)
        wall_limit_reg <= wr_data_reg[LIMIT_MSB:0];
    end
  end

  // periodic conversion request and bias window
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sample_cnt_reg <= 32'h0000_0000;
      busy_reg       <= 1'b0;
      conv_start_reg <= 1'b0;
      bias_reg       <= 1'b0;
    end
    else
    begin
      conv_start_reg <= 1'b0;
      // (R11) no sampling in ship-store
      if (ship_store_mode)
      begin
        sample_cnt_reg <= 32'h0000_0000;
        busy_reg       <= 1'b0;
        bias_reg       <= 1'b0;
      end
      else
      begin
        // (R11) period counter
        if (sample_cnt_reg == 32'(SAMPLE_CYCLES - 1))
          sample_cnt_reg <= 32'h0000_0000;
        else
          sample_cnt_reg <= sample_cnt_reg + 32'h0000_0001;
        if (busy_reg && adc_done)
        begin
          busy_reg <= 1'b0;
          bias_reg <= 1'b0;
        end
        else if (!busy_reg && sample_cnt_reg == 32'(SAMPLE_CYCLES - 1))
        begin
          busy_reg       <= 1'b1;
          bias_reg       <= 1'b1;
          conv_start_reg <= 1'b1;
        end
      end
    end
  end

  assign sample_done = busy_reg & adc_done & ~ship_store_mode;

  // (R11) result updated at end of sample
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      therm_reg <= 7'h00;
    else if (sample_done)
      therm_reg <= adc_result;
  end

  // cold warning with hysteresis
  tmic_hyst #(
    .SET_LVL  (COLD_SET_LVL),
    .CLR_LVL  (COLD_CLR_LVL),
    .HIGH_SET (1'b1)
  ) u_cold (
    .clk    (clk),
    .rst_b  (rst_b),
    .update (sample_done),
    .value  (adc_result),
    .flag   (cold_flag)
  );

  // hot fault with hysteresis
  tmic_hyst #(
    .SET_LVL  (HOT_SET_LVL),
    .CLR_LVL  (HOT_CLR_LVL),
    .HIGH_SET (1'b0)
  ) u_hot (
    .clk    (clk),
    .rst_b  (rst_b),
    .update (sample_done),
    .value  (adc_result),
    .flag   (hot_flag)
  );

  assign in_window = ~cold_flag & ~hot_flag;

  // pause, status field and charger state
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pause_reg     <= 1'b0;
      temp_stat_reg <= TEMP_OK;
      chg_stat_reg  <= 3'h0;
    end
    else
    begin
      // (R6) pause outside window
      pause_reg <= ~in_window;
      // (R7) encode flags
      if (hot_flag)
        temp_stat_reg <= TEMP_HOT;
      else if (cold_flag)
        temp_stat_reg <= TEMP_COLD;
      else
        temp_stat_reg <= TEMP_OK;
      // (R8) override only when enabled
      if (charger_enabled && hot_flag)
        chg_stat_reg <= CHG_HOT;
      else if (charger_enabled && cold_flag)
        chg_stat_reg <= CHG_COLD;
      else
        chg_stat_reg <= charger_state_in;
    end
  end

  // interrupt request pulses
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      window_prev_reg <= 1'b1;
      hot_prev_reg    <= 1'b0;
      chg_irq_reg     <= 1'b0;
      hot_irq_reg     <= 1'b0;
    end
    else
    begin
      window_prev_reg <= in_window;
      hot_prev_reg    <= hot_flag;
      // (R9) window entry or exit
      chg_irq_reg <= chg_irq_en & (in_window != window_prev_reg);
      // (R10) hot fault onset
      hot_irq_reg <= hot_irq_en & hot_flag & ~hot_prev_reg;
    end
  end

  // outputs straight from flops
  assign sda_out                    = sda_o_reg;
  assign sda_oe                     = sda_oe_reg;
  assign conv_start                 = conv_start_reg;
  assign thermistor_bias_supply     = bias_reg;
  assign thermistor_result          = therm_reg;
  assign cold_battery_warning       = cold_flag;
  assign critical_hot_fault         = hot_flag;
  assign charge_pause               = pause_reg;
  assign temp_status_field          = temp_stat_reg;
  assign charger_status             = chg_stat_reg;
  assign chg_irq_req                = chg_irq_reg;
  assign hot_irq_req                = hot_irq_reg;
  assign undervoltage_limit_disable = uvcl_dis_reg;
  assign otg_autostart_lockout      = otg_lock_reg;
  assign usb_input_limit_code       = usb_limit_reg;
  assign wall_input_limit_code      = wall_limit_reg;
  assign usb_priority               = prio_reg;

endmodule : tmic_top

/* File: verif/tmic_bench.sv */
// self-checking bench for the thermistor monitor and input control block
`timescale 1ns/1ps
module tmic_bench;
  import tmic_pkg::*;
  localparam int SAMPLES = 50;
  localparam int LIMIT   = 90000;
  logic       clk, rst_b, scl_in, sda_in, sda_out, sda_oe, host_sda_low, usb_pwr_ok, wall_pwr_ok;
  logic       ship_store_mode, adc_done, conv_start, thermistor_bias_supply, cold_battery_warning;
  logic       critical_hot_fault, charge_pause, charger_enabled, chg_irq_en, hot_irq_en, chg_irq_req;
  logic       hot_irq_req, undervoltage_limit_disable, otg_autostart_lockout, usb_priority;
  logic [6:0] adc_result, thermistor_result;
  logic [1:0] temp_status_field;
  logic [2:0] charger_state_in, charger_status;
  logic [4:0] usb_input_limit_code, wall_input_limit_code;
  logic [7:0] exp_q[$];
  logic [6:0] temps [12] = '{7'h3c, 7'h66, 7'h64, 7'h62, 7'h63, 7'h13, 7'h15, 7'h17, 7'h14, 7'h65, 7'h67, 7'h13};
  int         miscompares = 0, samples_checked = 0, cyc = 0, seed;

  tmic_top #(.SAMPLE_CYCLES(SAMPLES)) dut_u (.*);
  tmic_i2c_host host_u (.clk, .sda_line(sda_in), .scl_out(scl_in), .sda_low(host_sda_low));
  // open-drain data wire
  assign sda_in = !(host_sda_low || sda_oe);
  // 125 MHz clock
  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test
  // note the expected byte, then run the read
  task automatic rd(input logic [7:0] sub, input logic [7:0] want);
    exp_q.push_back(want);
    host_u.read_reg(sub);
  endtask : rd
  // cycle count and hang guard
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == LIMIT)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_of_test;
    end
  end
  // each finished read is matched against the oldest note
  always @(posedge clk)
    if (host_u.rd_valid === 1'b1)
      check(host_u.rd_byte, exp_q.pop_front());

  initial
  begin
    logic [6:0] v;
    logic       cold_m, hot_m, ok_old, hot_old;
    logic [7:0] d0, d1;
    int         t_last, n, convs;
    seed = 36253;
    {rst_b, adc_done, ship_store_mode, charger_enabled, chg_irq_en, hot_irq_en} = 6'h00;
    {usb_pwr_ok, wall_pwr_ok, cold_m, hot_m} = 4'hc;
    adc_result = 7'h00;
    charger_state_in = 3'h0;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // conversions answered after a random delay
    for (int i = 0; i < 12; i++)
    begin
      n = 0;
      while (conv_start !== 1'b1 && n < 4 * SAMPLES)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      if (i > 0)
        check(8'(cyc - t_last), 8'(SAMPLES));
      t_last = cyc;
      repeat (2 + {$random(seed)} % 4) @(posedge clk);
      #1;
      d0 = $random(seed);
      {charger_enabled, chg_irq_en, hot_irq_en, charger_state_in} = d0[5:0];
      v = temps[i];
      adc_result = v;
      adc_done = 1'b1;
      ok_old = !(cold_m || hot_m);
      hot_old = hot_m;
      if (v >= 7'h66)
        cold_m = 1'b1;
      else if (v <= 7'h62)
        cold_m = 1'b0;
      if (v <= 7'h13)
        hot_m = 1'b1;
      else if (v >= 7'h17)
        hot_m = 1'b0;
      d1 = {hot_m, hot_m ? TEMP_HOT : (cold_m ? TEMP_COLD : TEMP_OK), cold_m | hot_m, 4'h0};
      d1[3:2] = {chg_irq_en & (ok_old == (cold_m | hot_m)), hot_irq_en & hot_m & !hot_old};
      d0 = {5'h00, charger_enabled & hot_m ? CHG_HOT : (charger_enabled & cold_m ? CHG_COLD : charger_state_in)};
      @(posedge clk);
      #1;
      adc_done = 1'b0;
      check({thermistor_result, cold_battery_warning}, {v, cold_m});
      @(posedge clk);
      #1;
      check({critical_hot_fault, temp_status_field, charge_pause, chg_irq_req, hot_irq_req, 2'h0}, d1);
      check({5'h00, charger_status}, d0);
    end
    $display("test thermistor done");
    // no request while parked, one after, then left busy
    for (int ph = 0; ph < 2; ph++)
    begin
      ship_store_mode = !ph[0];
      convs = 0;
      repeat (3 * SAMPLES)
      begin
        @(posedge clk);
        #1;
        convs += conv_start;
      end
      check(8'(convs), 8'(ph));
    end
    check({1'b0, thermistor_result}, 8'h13);
    $display("test sampling done");
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h1f);
    // limit codes 0 to 15 and 0x1f, random upper bits
    for (int c = 0; c < 17; c++)
    begin
      d0 = $random(seed);
      d1 = $random(seed);
      d0[4:0] = (c == 16) ? 5'h1f : 5'(c);
      d1[4:0] = d0[4:0];
      host_u.write_pair(8'h00, {d0, d1});
      d0 = d0 & 8'hdf;
      d1 = d1 & 8'h9f;
      check({undervoltage_limit_disable, otg_autostart_lockout, 1'b0, usb_input_limit_code}, d0);
      check({usb_priority, 2'h0, wall_input_limit_code}, d1);
      rd({7'h00, c[0]}, c[0] ? d1 : d0);
    end
    host_u.write_pair(8'h04, 16'h5aa5);
    rd(8'h04, UNMAPPED_DATA);
    rd(8'h01, d1);
    $display("test registers done");
    {usb_pwr_ok, wall_pwr_ok} = 2'b00;
    host_u.write_pair(8'h00, 16'hca83);
    check({sda_out, 2'h0, usb_input_limit_code}, 8'h00);
    check({3'h0, wall_input_limit_code}, 8'h1f);
    {usb_pwr_ok, wall_pwr_ok} = 2'b11;
    rd(8'h00, 8'hc0);
    rd(8'h01, 8'h9f);
    check(host_u.nack_cnt, 8'h00);
    check(8'(exp_q.size()), 8'h00);
    $display("test power loss done");
    end_of_test;
  end
endmodule : tmic_bench

/* File: verif/tmic_i2c_host.sv */
// serial bus host model that runs register cycles
`timescale 1ns/1ps
module tmic_i2c_host
  import tmic_pkg::*;
(
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl_out,
  output logic      sda_low
);
  localparam int HALF = 16;
  logic [7:0] rd_byte = 8'h00;
  logic       rd_valid = 1'b0;
  logic [7:0] nack_cnt = 8'h00;
  // idle bus at time zero
  initial {scl_out, sda_low} = 2'b10;
  // wait n edges, then act just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // data while clock low, then clock high
  task automatic low_high(input logic low);
    tick(4);
    sda_low = low;
    tick(HALF - 4);
    scl_out = 1'b1;
    tick(HALF);
  endtask : low_high
  // one clock period, sampled at end of high
  task automatic clock_bit(input logic b, output logic s);
    low_high(!b);
    s = sda_line;
    scl_out = 1'b0;
  endtask : clock_bit
  // start, or repeated start when the clock is low
  task automatic start_cond;
    if (!scl_out)
      low_high(1'b0);
    sda_low = 1'b1;
    tick(HALF);
    scl_out = 1'b0;
  endtask : start_cond
  // stop: data rises while the clock is high
  task automatic stop_cond;
    low_high(1'b1);
    sda_low = 1'b0;
    tick(HALF);
  endtask : stop_cond
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic want_ack, output logic [7:0] rx);
    logic s;
    for (int i = 7; i >= 0; i--)
      clock_bit(tx[i], rx[i]);
    clock_bit(1'b1, s);
    if (want_ack && s)
      nack_cnt = nack_cnt + 8'h01;
  endtask : xfer
  // write two bytes from a sub address
  task automatic write_pair(input logic [7:0] sub, input logic [15:0] data);
    logic [7:0] rx;
    start_cond;
    xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, rx);
    xfer(sub, 1'b1, rx);
    xfer(data[15:8], 1'b1, rx);
    xfer(data[7:0], 1'b1, rx);
    stop_cond;
  endtask : write_pair
  // read one byte, ending with no acknowledge
  task automatic read_reg(input logic [7:0] sub);
    logic [7:0] rx;
    start_cond;
    xfer({I2C_DEV_ADDR, 1'b0}, 1'b1, rx);
    xfer(sub, 1'b1, rx);
    start_cond;
    xfer({I2C_DEV_ADDR, 1'b1}, 1'b1, rx);
    xfer(8'hff, 1'b0, rd_byte);
    stop_cond;
    rd_valid = 1'b1;
    tick(1);
    rd_valid = 1'b0;
  endtask : read_reg
endmodule : tmic_i2c_host

/* File: verif/tmic_properties.sv */
// port assertions for the thermistor monitor and input control block
`timescale 1ns/1ps
module tmic_properties
  import tmic_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       usb_pwr_ok,
  input wire logic       wall_pwr_ok,
  input wire logic       ship_store_mode,
  input wire logic [6:0] adc_result,
  input wire logic       adc_done,
  input wire logic       thermistor_bias_supply,
  input wire logic [6:0] thermistor_result,
  input wire logic       cold_battery_warning,
  input wire logic       critical_hot_fault,
  input wire logic       charge_pause,
  input wire logic [1:0] temp_status_field,
  input wire logic [2:0] charger_state_in,
  input wire logic       charger_enabled,
  input wire logic [2:0] charger_status,
  input wire logic       chg_irq_en,
  input wire logic       hot_irq_en,
  input wire logic       chg_irq_req,
  input wire logic       hot_irq_req,
  input wire logic [4:0] usb_input_limit_code,
  input wire logic [4:0] wall_input_limit_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // result accepted while busy
  wire logic take = adc_done && thermistor_bias_supply && !ship_store_mode;

  chk_result_load: assert property (take |=> thermistor_result == $past(adc_result))
    else $error("result not loaded");
  chk_cold_set: assert property (take && adc_result >= 7'h66 |=> cold_battery_warning)
    else $error("cold warning not set");
  chk_cold_clear: assert property (take && adc_result <= 7'h62 |=> !cold_battery_warning)
    else $error("cold warning not cleared");
  chk_hot_set: assert property (take && adc_result <= 7'h13 |=> critical_hot_fault)
    else $error("hot fault not set");
  chk_hot_clear: assert property (take && adc_result >= 7'h17 |=> !critical_hot_fault)
    else $error("hot fault not cleared");
  chk_pause_follow: assert property ($stable(cold_battery_warning || critical_hot_fault) |->
    charge_pause == (cold_battery_warning || critical_hot_fault))
    else $error("pause does not follow flags");
  chk_status_code: assert property ($stable({critical_hot_fault, cold_battery_warning}) |-> temp_status_field ==
    (critical_hot_fault ? TEMP_HOT : (cold_battery_warning ? TEMP_COLD : TEMP_OK)))
    else $error("status field wrong");
  chk_charger_code: assert property (1'b1 |=> charger_status == ($past(charger_enabled && critical_hot_fault) ?
    CHG_HOT : ($past(charger_enabled && cold_battery_warning) ? CHG_COLD : $past(charger_state_in))))
    else $error("charger status wrong");
  chk_window_irq: assert property ($changed(cold_battery_warning || critical_hot_fault) && chg_irq_en
    |=> chg_irq_req)
    else $error("window interrupt missing");
  chk_hot_irq: assert property ($rose(critical_hot_fault) && hot_irq_en |=> hot_irq_req)
    else $error("hot interrupt missing");
  chk_usb_revert: assert property (!usb_pwr_ok [*4] |-> usb_input_limit_code == 5'h00)
    else $error("usb limit not reverted");
  chk_wall_revert: assert property (!wall_pwr_ok [*4] |-> wall_input_limit_code == 5'h1f)
    else $error("wall limit not reverted");
endmodule : tmic_properties

bind tmic_top tmic_properties chk_u (.*);
